/* rtl/wtc_pkg.sv */
// Overview of operation
// - Enable bit three starts, zero stops
// - Zero accepted only while change window open
// - Disable write must land within four cycles
// - Safety level two never allows disabling
// - Level one: reset flag forces enable
// - Timeout select: bit five high, bits 2:0
// - Timeout is 2048 ticks shifted by code
// - Reserved codes fall back to valid code
// - Watchdog reset restarts at vector zero
// - Counter runs from 128 kHz tick
// - Kick restarts counter; expiry resets device unless irq enable set
// - Change window closes four cycles after set
// - Interrupt timeout clears irq enable when enabled
`default_nettype none
package wtc_pkg;

   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ       = 100_000_000;
   localparam int unsigned OSC_HZ       = 128_000;
   localparam int unsigned OSC_DIV      = CLK_HZ / OSC_HZ;
   localparam int unsigned CHG_WIN_CYC  = 4;
   localparam int unsigned TMO_BASE     = 2048;
   localparam int unsigned TMO_CW       = 21;
   localparam logic [3:0]  SEL_MAX      = 4'h9;
   localparam logic [15:0] RESET_VECTOR = 16'h0000;

   // ----------------------------------------
   // Register word indices, byte offsets noted
   // ----------------------------------------
   localparam logic [2:0] IDX_CTRL   = 3'h0;  // dog_control at 0x00
   localparam logic [2:0] IDX_CAUSE  = 3'h1;  // reset_cause_register 0x04
   localparam logic [2:0] IDX_STATUS = 3'h2;  // Event status, 0x08
   localparam logic [2:0] IDX_MASK   = 3'h3;  // Event mask, 0x0C
   localparam logic [2:0] IDX_KICK   = 3'h4;  // Counter restart, 0x10

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int unsigned CTL_IRQF = 7;
   localparam int unsigned CTL_IE   = 6;
   localparam int unsigned CTL_SEL3 = 5;
   localparam int unsigned CTL_CE   = 4;
   localparam int unsigned CTL_EN   = 3;
   localparam int unsigned CAU_DRF  = 3;
   localparam int unsigned ST_TMO   = 0;
   localparam int unsigned ST_DRST  = 1;

   // ----------------------------------------
   // Block state
   // ----------------------------------------
   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
      logic        irq_flag;
      logic        ie;
      logic [3:0]  sel;
      logic        cwin;
      logic [2:0]  cwin_cnt;
      logic        en;
      logic        rst_flag;
      logic [1:0]  status;
      logic [1:0]  mask;
      logic        lvl2;
      logic        lvl_done;
      logic        dog_rst;
   } wtc_state_t;

   localparam wtc_state_t STATE_RESET = '0;

endpackage : wtc_pkg
`default_nettype wire

/* rtl/wtc_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module wtc_tick
#(
   parameter int unsigned DIV = wtc_pkg::OSC_DIV
)
(
   input  wire logic CLK_SYS_I,
   input  wire logic RESET_I,
   output logic      tick_o
);

   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;

   // ----------------------------------------
   // Oscillator tick divider
   // ----------------------------------------
   // Slow tick enable
   always_comb
   begin
      cnt_nxt = cnt_r + 16'h0001;
      tick_o  = (cnt_r == 16'(DIV - 1));
      if (tick_o)
      begin
         cnt_nxt = 16'h0000;
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         cnt_r <= 16'h0000;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end

   AST_TICK_GAP : assert property (
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      tick_o |=> !tick_o && cnt_r == 16'h0000)
      else $error("Tick did not restart divider");

   AST_TICK_RANGE : assert property (
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      cnt_r < 16'(DIV))
      else $error("Tick divider overran");

endmodule : wtc_tick
`default_nettype wire

/* rtl/wtc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module wtc_timer
#(
   parameter int unsigned CW = wtc_pkg::TMO_CW
)
(
   input  wire logic       CLK_SYS_I,
   input  wire logic       RESET_I,
   input  wire logic       tick_i,
   input  wire logic       restart_i,
   input  wire logic [3:0] sel_i,
   output logic            expire_o
);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic [CW-1:0] limit;

   // ----------------------------------------
   // Timeout counter
   // ----------------------------------------
   // Period doubles per code
   always_comb
   begin
      limit    = CW'(wtc_pkg::TMO_BASE) << sel_i;
      expire_o = tick_i && !restart_i && (cnt_r == limit - 1'b1);
      cnt_nxt  = cnt_r;
      if (restart_i || expire_o)
      begin
         cnt_nxt = '0;
      end
      else if (tick_i)
      begin
         cnt_nxt = cnt_r + 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         cnt_r <= '0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end

endmodule : wtc_timer
`default_nettype wire

/* rtl/wtc_top.sv */
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module wtc_top
#(
   parameter int unsigned DIV = wtc_pkg::OSC_DIV
)
(
   input  wire logic        CLK_SYS_I,
   input  wire logic        RESET_I,
   input  wire logic [4:0]  AVS_ADDRESS_I,
   input  wire logic        AVS_READ_I,
   input  wire logic        AVS_WRITE_I,
   input  wire logic [31:0] AVS_WRITEDATA_I,
   input  wire logic [3:0]  AVS_BYTEENABLE_I,
   output logic [31:0]      AVS_READDATA_O,
   output logic             AVS_WAITREQUEST_O,
   input  wire logic        SAFETY_LEVEL_FUSE_I,
   output logic             IRQ_O,
   output logic             DOG_RESET_O,
   output logic [15:0]      RESET_VECTOR_O
);

   wtc_pkg::wtc_state_t s_r;
   wtc_pkg::wtc_state_t s_nxt;

   logic       tick;
   logic       expire;
   logic       restart;
   logic       en_eff;
   logic       running;
   logic       req;
   logic       wr;
   logic [2:0] idx;
   logic [7:0] wd;
   logic [7:0] ctrl_rd;
   logic [3:0] sel_wr;

   // ----------------------------------------
   // Slow tick and timeout counter
   // ----------------------------------------
   wtc_tick
   #(
      .DIV       (DIV)
   )
   u_tick
   (
      .CLK_SYS_I (CLK_SYS_I),
      .RESET_I   (RESET_I),
      .tick_o    (tick)
   );

   wtc_timer u_timer
   (
      .CLK_SYS_I (CLK_SYS_I),
      .RESET_I   (RESET_I),
      .tick_i    (tick),
      .restart_i (restart),
      .sel_i     (s_r.sel),
      .expire_o  (expire)
   );

   // ----------------------------------------
   // Decode and effective enable
   // ----------------------------------------
   // Bus handshake: one wait cycle per access
   always_comb
   begin
      req     = AVS_READ_I || AVS_WRITE_I;
      idx     = AVS_ADDRESS_I[4:2];
      wd      = AVS_WRITEDATA_I[7:0];
      wr      = AVS_WRITE_I && s_r.ack && AVS_BYTEENABLE_I[0];
      en_eff  = s_r.en || s_r.lvl2 || s_r.rst_flag;
      // Interrupt mode keeps it counting too
      running = en_eff || s_r.ie;
      restart = (wr && idx == wtc_pkg::IDX_KICK) || !running
                || s_r.dog_rst;
      ctrl_rd = {s_r.irq_flag, s_r.ie, s_r.sel[3], s_r.cwin,
                 en_eff, s_r.sel[2:0]};
      sel_wr  = {wd[wtc_pkg::CTL_SEL3], wd[2:0]};
      if (sel_wr > wtc_pkg::SEL_MAX)
      begin
         sel_wr = wtc_pkg::SEL_MAX;
      end
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   // Writes first, hardware sets last so sets win
   always_comb
   begin
      s_nxt         = s_r;
      s_nxt.ack     = req && !s_r.ack;
      s_nxt.dog_rst = 1'b0;

      if (!s_r.lvl_done)
      begin
         s_nxt.lvl2     = SAFETY_LEVEL_FUSE_I;
         s_nxt.lvl_done = 1'b1;
      end

      // Read data registered in the wait cycle
      if (req && !s_r.ack)
      begin
         case (idx)
            wtc_pkg::IDX_CTRL:
               s_nxt.rdata = {24'h000000, ctrl_rd};
            wtc_pkg::IDX_CAUSE:
               s_nxt.rdata = {28'h0000000, s_r.rst_flag, 3'h0};
            wtc_pkg::IDX_STATUS:
               s_nxt.rdata = {30'h00000000, s_r.status};
            wtc_pkg::IDX_MASK:
               s_nxt.rdata = {30'h00000000, s_r.mask};
            default:
               s_nxt.rdata = 32'h00000000;
         endcase
      end

      if (s_r.cwin)
      begin
         s_nxt.cwin_cnt = s_r.cwin_cnt - 3'h1;
         if (s_r.cwin_cnt == 3'h1)
         begin
            s_nxt.cwin = 1'b0;
         end
      end

      // Register writes
      if (wr)
      begin
         case (idx)
            wtc_pkg::IDX_CTRL:
            begin
               s_nxt.ie = wd[wtc_pkg::CTL_IE];
               if (wd[wtc_pkg::CTL_IRQF])
               begin
                  s_nxt.irq_flag = 1'b0;
               end
               if (!s_r.lvl2 || s_r.cwin)
               begin
                  s_nxt.sel = sel_wr;
               end
               if (wd[wtc_pkg::CTL_EN])
               begin
                  s_nxt.en = 1'b1;
               end
               else if (s_r.cwin && !s_r.lvl2 && !s_r.rst_flag)
               begin
                  s_nxt.en = 1'b0;
               end
               if (wd[wtc_pkg::CTL_CE] && wd[wtc_pkg::CTL_EN])
               begin
                  s_nxt.cwin     = 1'b1;
                  s_nxt.cwin_cnt = 3'(wtc_pkg::CHG_WIN_CYC);
               end
               else if (!wd[wtc_pkg::CTL_CE])
               begin
                  s_nxt.cwin = 1'b0;
               end
            end
            wtc_pkg::IDX_CAUSE:
            begin
               // Flag is cleared by writing zero
               if (!wd[wtc_pkg::CAU_DRF])
               begin
                  s_nxt.rst_flag = 1'b0;
               end
            end
            wtc_pkg::IDX_STATUS:
               s_nxt.status = s_r.status & ~wd[1:0];
            wtc_pkg::IDX_MASK:
               s_nxt.mask = wd[1:0];
            default:
               s_nxt.mask = s_nxt.mask;
         endcase
      end

      // Timeout action
      if (expire)
      begin
         if (s_r.ie)
         begin
            s_nxt.irq_flag              = 1'b1;
            s_nxt.status[wtc_pkg::ST_TMO] = 1'b1;
            if (en_eff)
            begin
               s_nxt.ie = 1'b0;
            end
         end
         else if (en_eff)
         begin
            s_nxt.dog_rst                  = 1'b1;
            s_nxt.rst_flag                 = 1'b1;
            s_nxt.status[wtc_pkg::ST_DRST] = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge CLK_SYS_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         s_r <= wtc_pkg::STATE_RESET;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Level interrupt from unmasked events
   always_comb
   begin
      AVS_WAITREQUEST_O = req && !s_r.ack;
      AVS_READDATA_O    = s_r.rdata;
      IRQ_O             = |(s_r.status & s_r.mask);
      DOG_RESET_O       = s_r.dog_rst;
      RESET_VECTOR_O    = wtc_pkg::RESET_VECTOR;
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Enable write starts
   AST_EN_SET : assert property (
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      (wr && idx == wtc_pkg::IDX_CTRL && wd[wtc_pkg::CTL_EN]) |=> en_eff)
      else $error("Enable write did not start dog");

   AST_NO_CLEAR : assert property (
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      (wr && idx == wtc_pkg::IDX_CTRL && !s_r.cwin && en_eff) |=> en_eff)
      else $error("Enable cleared outside window");

   AST_CLR_IN_WIN : assert property (
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      (wr && idx == wtc_pkg::IDX_CTRL && !wd[wtc_pkg::CTL_EN] && s_r.cwin
       && !s_r.lvl2 && !s_r.rst_flag) |=> !s_r.en)
      else $error("Disable inside window ignored");

   AST_WIN_LEN : assert property (
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      $rose(s_r.cwin) |-> s_r.cwin_cnt == 3'(wtc_pkg::CHG_WIN_CYC))
      else $error("Change window length wrong");

   AST_WIN_CNT : assert property (
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      (s_r.cwin && !wr) |=> !s_r.cwin
      || s_r.cwin_cnt == $past(s_r.cwin_cnt) - 3'h1)
      else $error("Change window count skipped");

   AST_WIN_END : assert property (
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      (s_r.cwin && s_r.cwin_cnt == 3'h1 && !wr) |=> !s_r.cwin)
      else $error("Change window stayed open");

   AST_LVL2_ON : assert property (
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      s_r.lvl2 |-> en_eff && ctrl_rd[wtc_pkg::CTL_EN])
      else $error("Level two dog not enabled");

   AST_LVL2_SEL : assert property (
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      (s_r.lvl2 && !s_r.cwin) |=> $stable(s_r.sel))
      else $error("Level two period changed outside window");

   AST_FLAG_FORCE : assert property (
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      s_r.rst_flag |-> ctrl_rd[wtc_pkg::CTL_EN])
      else $error("Reset flag did not force enable");

   AST_SEL_SPLIT : assert property (
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      (wr && idx == wtc_pkg::IDX_CTRL && !s_r.lvl2
       && {wd[wtc_pkg::CTL_SEL3], wd[2:0]} <= wtc_pkg::SEL_MAX)
      |=> s_r.sel == $past({wd[wtc_pkg::CTL_SEL3], wd[2:0]}))
      else $error("Timeout select bits misplaced");

   AST_SEL_VALID : assert property (
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      s_r.sel <= wtc_pkg::SEL_MAX)
      else $error("Reserved timeout code stored");

   AST_IE_CLR : assert property (
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      (expire && s_r.ie && en_eff) |=> !s_r.ie && s_r.irq_flag)
      else $error("Irq enable not cleared on timeout");

   AST_TMO_IRQ : assert property (
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      (expire && s_r.ie) |=> s_r.status[wtc_pkg::ST_TMO] && !DOG_RESET_O)
      else $error("Interrupt timeout mishandled");

   AST_DOG_RST : assert property (
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      DOG_RESET_O |-> s_r.rst_flag && RESET_VECTOR_O == 16'h0000
      ##1 !DOG_RESET_O)
      else $error("Dog reset pulse wrong");

   AST_RST_STATUS : assert property (
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      DOG_RESET_O |-> s_r.status[wtc_pkg::ST_DRST])
      else $error("Dog reset not logged");

   AST_LVL_FIXED : assert property (
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      s_r.lvl_done |=> $stable(s_r.lvl2))
      else $error("Safety level changed after reset");

   // Bus answers after one wait cycle
   AST_ACK_ONE : assert property (
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      (req && !s_r.ack) |=> !AVS_WAITREQUEST_O)
      else $error("Bus wait longer than one cycle");

endmodule : wtc_top
`default_nettype wire

/* test/wtc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module wtc_core_model
(
   input  wire logic        clk_i,
   input  wire logic        wait_i,
   input  wire logic [31:0] rdata_i,
   output logic [4:0]       addr_o,
   output logic             rd_o,
   output logic             wr_o,
   output logic [31:0]      wdata_o,
   output logic [3:0]       be_o
);
   bit held = 1'b0;

   // Idle bus at time zero
   initial
   begin
      addr_o  = 5'h00;
      rd_o    = 1'b0;
      wr_o    = 1'b0;
      wdata_o = 32'h00000000;
      be_o    = 4'hF;
   end

   // --------------------------------------------
   // Bus access
   // --------------------------------------------
   // Chained calls keep the strobe up, so no idle edge is lost
   task automatic xfer(input bit we, input logic [4:0] a,
                       input logic [7:0] d, input bit rel,
                       output logic [7:0] q);
      if (!held)
         @(posedge clk_i);
      addr_o  <= a;
      rd_o    <= !we;
      wr_o    <= we;
      wdata_o <= {24'h000000, d};
      // Wait request and read data judged at the rising edge only
      do
         @(posedge clk_i);
      while (wait_i !== 1'b0);
      q    = rdata_i[7:0];
      held = !rel;
      if (rel)
      begin
         rd_o <= 1'b0;
         wr_o <= 1'b0;
      end
   endtask : xfer

   task automatic wr(input logic [4:0] a, input logic [7:0] d,
                     input bit rel = 1'b1);
      logic [7:0] q;
      xfer(1'b1, a, d, rel, q);
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [7:0] q);
      xfer(1'b0, a, 8'h00, 1'b1, q);
   endtask : rd

   task automatic dis_seq;
      wr(5'h00, 8'h18, 1'b0);
      wr(5'h00, 8'h00);
   endtask : dis_seq
endmodule : wtc_core_model
`default_nettype wire

/* test/wtc_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module wtc_bench;
   localparam int DIV = 2;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        fuse = 1'b0;
   logic [4:0]  addr;
   logic        rd;
   logic        wr;
   logic [31:0] wdata;
   logic [3:0]  be;
   logic [31:0] rdata;
   logic        waitreq;
   logic        irq;
   logic        dog_rst;
   logic [15:0] vec;
   int          fail_count = 0;
   int          total_checks = 0;

   wtc_top #(.DIV(DIV)) DUT (
      .CLK_SYS_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(addr),
      .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
      .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
      .AVS_WAITREQUEST_O(waitreq), .SAFETY_LEVEL_FUSE_I(fuse),
      .IRQ_O(irq), .DOG_RESET_O(dog_rst), .RESET_VECTOR_O(vec));

   wtc_core_model core (
      .clk_i(clk), .wait_i(waitreq), .rdata_i(rdata), .addr_o(addr),
      .rd_o(rd), .wr_o(wr), .wdata_o(wdata), .be_o(be));

   // 100 MHz system clock
   initial
   begin
      forever #5 clk = ~clk;
   end

   // --------------------------------------------
   // Helpers
   // --------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] q;
      core.rd(a, q);
      chk({24'h000000, q}, {24'h000000, exp});
   endtask : rdchk

   // Level output follows the register write on the same edge
   task automatic irqchk(input logic exp);
      repeat (2) @(posedge clk);
      #1;
      chk({31'h0, irq}, {31'h0, exp});
   endtask : irqchk

   task automatic do_reset(input logic f);
      fuse <= f;
      rst  <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : do_reset

   // Tick phase makes the expiry edge uncertain by a tick or two
   task automatic wait_ev(input bit on_irq, input int sel);
      int t;
      int n;
      t = (2048 << sel) * DIV;
      n = 0;
      while (n <= t + 2 * DIV + 4 && (on_irq ? irq : dog_rst) !== 1'b1)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(32'(n >= t - 2 * DIV && n <= t + 2 * DIV + 4), 32'h1);
   endtask : wait_ev

   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude

   // --------------------------------------------
   // Scenarios
   // --------------------------------------------
   task automatic t_window;
      core.wr(5'h00, 8'h08);
      core.wr(5'h00, 8'h00);
      rdchk(5'h00, 8'h08);
      core.wr(5'h00, 8'h18, 1'b0);
      rdchk(5'h00, 8'h18);
      repeat (6) @(posedge clk);
      rdchk(5'h00, 8'h08);
      core.wr(5'h00, 8'h18);
      repeat (4) @(posedge clk);
      core.wr(5'h00, 8'h00);
      rdchk(5'h00, 8'h08);
      core.dis_seq();
      rdchk(5'h00, 8'h00);
   endtask : t_window

   task automatic t_irq;
      core.wr(5'h0C, 8'h01);
      core.wr(5'h00, 8'h49);
      core.wr(5'h10, 8'h00);
      wait_ev(1'b1, 1);
      rdchk(5'h00, 8'h89);
      rdchk(5'h08, 8'h01);
      core.wr(5'h0C, 8'h00);
      irqchk(1'b0);
      core.wr(5'h0C, 8'h01);
      irqchk(1'b1);
      core.wr(5'h08, 8'h01);
      irqchk(1'b0);
   endtask : t_irq

   // Interrupt enable now clear, so the next expiry resets
   task automatic t_dogrst;
      core.wr(5'h10, 8'h00);
      wait_ev(1'b0, 1);
      chk({16'h0000, vec}, 32'h00000000);
      rdchk(5'h04, 8'h08);
      rdchk(5'h08, 8'h02);
      core.dis_seq();
      rdchk(5'h00, 8'h88);
      core.wr(5'h04, 8'h00);
      core.dis_seq();
      rdchk(5'h00, 8'h80);
   endtask : t_dogrst

   task automatic t_level2;
      do_reset(1'b1);
      rdchk(5'h00, 8'h08);
      core.dis_seq();
      rdchk(5'h00, 8'h08);
   endtask : t_level2

   // Main sequence
   initial
   begin
      do_reset(1'b0);
      rdchk(5'h00, 8'h00);
      rdchk(5'h04, 8'h00);
      rdchk(5'h08, 8'h00);
      rdchk(5'h0C, 8'h00);
      rdchk(5'h14, 8'h00);
      core.wr(5'h00, 8'h2F);
      rdchk(5'h00, 8'h29);
      t_window();
      t_irq();
      t_dogrst();
      t_level2();
      conclude();
   end

   // Hang guard, well past the longest expected run
   initial
   begin
      repeat (40000) @(posedge clk);
      fail_count++;
      conclude();
   end
endmodule : wtc_bench
`default_nettype wire
